// ---- hdl/arpct_pkg.sv ----
/*
 * shared constants and carrier types of the auto-reload pwm capture timer.
 * assumes a single 100 MHz system clock and active-low asynchronous reset.
 */
package arpct_pkg;

    // ==========================================================
    // widths and counts
    localparam int CNT_W = 8;
    localparam int PRE_W = 7;
    localparam int TAP_W = 3;
    localparam int PWM_CH = 2;
    localparam int CAP_CH = 2;

    // ==========================================================
    // values
    localparam logic [7:0] CNT_RESET = 8'h00;
    localparam logic [7:0] CNT_TOP = 8'hFF;
    localparam logic [7:0] DUTY_ALWAYS_LOW = 8'hFF;
    localparam logic [7:0] DUTY_ALWAYS_HIGH = 8'h00;
    localparam logic [7:0] SHADOW_RESET = 8'h00;
    localparam logic [6:0] PRE_RESET = 7'h00;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic external_clock_select;
        logic [2:0] prescaler_tap_select;
        logic counter_run_enable;
        logic overflow_irq_enable;
    } arpct_ctl_t;

    typedef struct packed {
        logic [1:0] output_enable_bits;
        logic [1:0] output_polarity_bits;
    } arpct_pwm_ctl_t;

    typedef struct packed {
        logic [1:0] capture_edge_select;
        logic [1:0] capture_irq_enable;
    } arpct_cap_ctl_t;

    localparam arpct_ctl_t CTL_RESET = '0;
    localparam arpct_pwm_ctl_t PWM_CTL_RESET = '0;
    localparam arpct_cap_ctl_t CAP_CTL_RESET = '0;

endpackage

// ---- hdl/arpct_prescaler.sv ----
/*
 * power-of-two prescaler: counts input ticks, emits a one-cycle
 * counter tick on the selected tap. assumes ticks are clk_sys pulses.
 */
`timescale 1ns/1ps
module arpct_prescaler #(
    parameter int PW = arpct_pkg::PRE_W
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic in_tick,
    input wire logic run,
    input wire logic clear,
    input wire logic [arpct_pkg::TAP_W-1:0] tap,
    output logic out_tick
);
    import arpct_pkg::*;

    logic [PW-1:0] pre;
    logic [PW:0] mask;

    // ==========================================================
    // tap mask: low tap bits all ones ends a divided period
    always_comb begin
        mask = (PW+1)'((1 << tap) - 1);
        out_tick = run && in_tick && ((pre & mask[PW-1:0]) == mask[PW-1:0]);
    end

    // ==========================================================
    // prescaler count
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pre <= PRE_RESET;
        end else if (clear) begin
            pre <= PRE_RESET;
        end else if (run && in_tick) begin
            pre <= pre + 1'b1;
        end
    end

endmodule

// ---- hdl/arpct_capture.sv ----
/*
 * one input capture channel: edge detect, counter-clock synchronised
 * flag, locked capture value. assumes pin is synchronous to clk_sys.
 */
`timescale 1ns/1ps
module arpct_capture #(
    parameter int CW = arpct_pkg::CNT_W
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic pin,
    input wire logic rise_sel,
    input wire logic irq_en,
    input wire logic sync_tick,
    input wire logic halt_mode,
    input wire logic status_read,
    input wire logic [CW-1:0] count,
    output logic [CW-1:0] value,
    output logic flag,
    output logic irq
);
    import arpct_pkg::*;

    logic pin_d;
    logic pending;
    logic edge_seen;
    logic set_flag;

    // ==========================================================
    // edge detect and counter-clock synchronisation
    assign edge_seen = rise_sel ? (pin && !pin_d) : (!pin && pin_d);
    assign set_flag = (pending || edge_seen) && sync_tick;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pin_d <= 1'b0;
        end else begin
            pin_d <= pin;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pending <= 1'b0;
        end else if (set_flag) begin
            pending <= 1'b0;
        end else if (edge_seen) begin
            pending <= 1'b1;
        end
    end

    // ==========================================================
    // flag: set wins over the read clear
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            flag <= 1'b0;
        end else if (set_flag) begin
            flag <= 1'b1;
        end else if (status_read) begin
            flag <= 1'b0;
        end
    end

    // ==========================================================
    // value locked while flag stands, frozen in halt
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            value <= '0;
        end else if (set_flag && !flag && !halt_mode) begin
            value <= count;
        end
    end

    assign irq = flag && irq_en;

endmodule

// ---- hdl/arpct_timer.sv ----
/*
 * auto-reload pwm capture timer: 8-bit reload counter with prescaler,
 * two pwm outputs, overflow flag, two capture channels.
 * assumes all inputs synchronous to clk_sys; software accesses are
 * one-cycle strobes on plain ports.
 */
`timescale 1ns/1ps
module arpct_timer #(
    parameter int CW = arpct_pkg::CNT_W,
    parameter int PW = arpct_pkg::PRE_W
) (
    input wire logic clk_sys,
    input wire logic rstn,
    // control and status
    input wire arpct_pkg::arpct_ctl_t timer_control_status,
    input wire logic force_reload,
    input wire logic status_read,
    output logic overflow_flag,
    output logic overflow_irq,
    // counter and reload
    input wire logic [CW-1:0] reload_value_register,
    input wire logic counter_write,
    input wire logic [CW-1:0] counter_write_data,
    output logic [CW-1:0] counter_access_register,
    // pwm
    input wire arpct_pkg::arpct_pwm_ctl_t pwm_control_register,
    input wire logic [CW-1:0] duty_cycle_register_0,
    input wire logic [CW-1:0] duty_cycle_register_1,
    output logic [arpct_pkg::PWM_CH-1:0] pwm_output_pin,
    output logic [arpct_pkg::PWM_CH-1:0] pwm_output_pin_oe,
    // capture
    input wire arpct_pkg::arpct_cap_ctl_t capture_control_status,
    input wire logic capture_status_read,
    input wire logic [arpct_pkg::CAP_CH-1:0] capture_input_pin,
    output logic [CW-1:0] capture_value_register_0,
    output logic [CW-1:0] capture_value_register_1,
    output logic [arpct_pkg::CAP_CH-1:0] capture_flag,
    output logic [arpct_pkg::CAP_CH-1:0] capture_irq,
    // system
    input wire logic event_clock_pin,
    input wire logic halt_mode,
    output logic wake_request
);
    import arpct_pkg::*;

    arpct_ctl_t ctl;
    arpct_pwm_ctl_t pwm_ctl;
    arpct_cap_ctl_t cap_ctl;
    logic event_d;
    logic event_tick;
    logic input_tick;
    logic run;
    logic pre_clear;
    logic count_tick;
    logic overflow_event;
    logic force_load;
    logic [CW-1:0] count;
    logic [CW-1:0] next_count;
    logic [CW-1:0] duty [PWM_CH];
    logic [CW-1:0] shadow [PWM_CH];
    logic [PWM_CH-1:0] next_level;
    logic [CW-1:0] cap_value [CAP_CH];
    logic cap_sync;

    // ==========================================================
    // control latches, frozen while halted
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ctl <= CTL_RESET;
        end else if (!halt_mode) begin
            ctl <= timer_control_status;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pwm_ctl <= PWM_CTL_RESET;
        end else if (!halt_mode) begin
            pwm_ctl <= pwm_control_register;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cap_ctl <= CAP_CTL_RESET;
        end else if (!halt_mode) begin
            cap_ctl <= capture_control_status;
        end
    end

    // ==========================================================
    // clock source selection
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            event_d <= 1'b0;
        end else begin
            event_d <= event_clock_pin;
        end
    end

    assign event_tick = event_clock_pin && !event_d;

    always_comb begin
        if (ctl.external_clock_select) begin
            input_tick = event_tick;
        end else begin
            // cpu clock stops while halted
            input_tick = !halt_mode;
        end
    end

    assign run = ctl.counter_run_enable;
    assign force_load = force_reload && timer_control_status.counter_run_enable && !halt_mode;
    assign pre_clear = (counter_write && !halt_mode) || force_load;

    // ==========================================================
    // prescaler
    arpct_prescaler #(
        .PW(PW)
    ) u_prescaler (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .in_tick(input_tick),
        .run(run),
        .clear(pre_clear),
        .tap(ctl.prescaler_tap_select),
        .out_tick(count_tick)
    );

    // ==========================================================
    // counter
    assign overflow_event = count_tick && !pre_clear && (count == CNT_TOP);

    always_comb begin
        next_count = count;
        if (counter_write && !halt_mode) begin
            next_count = counter_write_data;
        end else if (force_load) begin
            next_count = reload_value_register;
        end else if (count_tick) begin
            if (count == CNT_TOP) begin
                next_count = reload_value_register;
            end else begin
                next_count = count + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            count <= CNT_RESET;
        end else begin
            count <= next_count;
        end
    end

    assign counter_access_register = count;

    // ==========================================================
    // overflow flag: set wins over read clear
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            overflow_flag <= 1'b0;
        end else if (overflow_event) begin
            overflow_flag <= 1'b1;
        end else if (status_read) begin
            overflow_flag <= 1'b0;
        end
    end

    assign overflow_irq = overflow_flag && ctl.overflow_irq_enable;

    // ==========================================================
    // pwm channels
    assign duty[0] = duty_cycle_register_0;
    assign duty[1] = duty_cycle_register_1;

    generate
        for (genvar i = 0; i < PWM_CH; i++) begin : g_pwm
            always_ff @(posedge clk_sys or negedge rstn) begin
                if (!rstn) begin
                    shadow[i] <= SHADOW_RESET;
                end else if (overflow_event) begin
                    shadow[i] <= duty[i];
                end
            end

            always_comb begin
                if (shadow[i] == DUTY_ALWAYS_LOW) begin
                    next_level[i] = 1'b0;
                end else if (shadow[i] == DUTY_ALWAYS_HIGH) begin
                    next_level[i] = 1'b1;
                end else begin
                    next_level[i] = (count <= shadow[i]);
                end
            end

            always_ff @(posedge clk_sys or negedge rstn) begin
                if (!rstn) begin
                    pwm_output_pin[i] <= 1'b0;
                end else if (!halt_mode) begin
                    pwm_output_pin[i] <= next_level[i] ^ pwm_ctl.output_polarity_bits[i];
                end
            end

            always_ff @(posedge clk_sys or negedge rstn) begin
                if (!rstn) begin
                    pwm_output_pin_oe[i] <= 1'b0;
                end else begin
                    pwm_output_pin_oe[i] <= pwm_ctl.output_enable_bits[i];
                end
            end
        end
    endgenerate

    // ==========================================================
    // capture channels
    // halted or stopped counter: flag edges directly so wake still works
    assign cap_sync = count_tick || halt_mode || !run;

    generate
        for (genvar c = 0; c < CAP_CH; c++) begin : g_cap
            arpct_capture #(
                .CW(CW)
            ) u_capture (
                .clk_sys(clk_sys),
                .rstn(rstn),
                .pin(capture_input_pin[c]),
                .rise_sel(cap_ctl.capture_edge_select[c]),
                .irq_en(cap_ctl.capture_irq_enable[c]),
                .sync_tick(cap_sync),
                .halt_mode(halt_mode),
                .status_read(capture_status_read),
                .count(count),
                .value(cap_value[c]),
                .flag(capture_flag[c]),
                .irq(capture_irq[c])
            );
        end
    endgenerate

    assign capture_value_register_0 = cap_value[0];
    assign capture_value_register_1 = cap_value[1];

    // ==========================================================
    // wake from halt
    assign wake_request = halt_mode && (overflow_irq || (|capture_irq));

endmodule

// ---- dv/arpct_timer_properties.sv ----
/* port checker for arpct_timer.
   one clock domain; sees top-level ports only. */
`timescale 1ns/1ps
module arpct_timer_chk
    import arpct_pkg::*;
#(
    parameter int CW = 8
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire arpct_pkg::arpct_ctl_t timer_control_status,
    input wire logic force_reload,
    input wire logic status_read,
    input wire logic overflow_flag,
    input wire logic overflow_irq,
    input wire logic [CW-1:0] reload_value_register,
    input wire logic counter_write,
    input wire logic [CW-1:0] counter_write_data,
    input wire logic [CW-1:0] counter_access_register,
    input wire arpct_pkg::arpct_pwm_ctl_t pwm_control_register,
    input wire logic [1:0] pwm_output_pin,
    input wire logic [1:0] pwm_output_pin_oe,
    input wire logic [CW-1:0] capture_value_register_0,
    input wire logic [1:0] capture_flag,
    input wire logic [1:0] capture_irq,
    input wire logic halt_mode,
    input wire logic wake_request
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    wire [CW-1:0] cnt = counter_access_register;
    // ==========
    // assertions
    a_write_loads: assert property (
        counter_write && !halt_mode |=> cnt == $past(counter_write_data)) else $error("write lost");
    a_ovf_reload: assert property (
        $past(cnt) == 8'hFF && cnt != 8'hFF && !$past(counter_write) && !$past(force_reload)
        |-> overflow_flag && cnt == $past(reload_value_register)) else $error("bad reload");
    a_read_clears: assert property (
        status_read |=> !overflow_flag || $past(cnt) == 8'hFF) else $error("flag kept");
    a_ovf_irq: assert property (
        overflow_flag && $past(timer_control_status.overflow_irq_enable) && !$past(halt_mode)
        |-> overflow_irq) else $error("no overflow irq");
    a_oe_follows: assert property (
        (!halt_mode && $stable(pwm_control_register)) [*3]
        |-> pwm_output_pin_oe == pwm_control_register.output_enable_bits) else $error("bad oe");
    a_cap_lock: assert property (
        capture_flag[0] && $past(capture_flag[0]) |-> $stable(capture_value_register_0))
        else $error("capture not locked");
    a_wake_src: assert property (
        wake_request || halt_mode
        |-> wake_request == (halt_mode && (overflow_irq || capture_irq != 2'b00)))
        else $error("bad wake");
    a_halt_pwm: assert property (
        halt_mode [*3] |-> $stable(pwm_output_pin)) else $error("pwm moved in halt");
    a_run_frozen: assert property (
        (!timer_control_status.counter_run_enable && !counter_write && !halt_mode) [*2]
        |=> $stable(cnt)) else $error("counter moved");
    c_ovf: cover property ($rose(overflow_flag));
    c_cap: cover property (capture_flag == 2'b11);
    c_wake: cover property ($rose(wake_request));
endmodule

bind arpct_timer arpct_timer_chk #(.CW(CW)) u_chk (
    .clk_sys, .rstn, .timer_control_status, .force_reload, .status_read, .overflow_flag,
    .overflow_irq, .reload_value_register, .counter_write, .counter_write_data,
    .counter_access_register, .pwm_control_register, .pwm_output_pin, .pwm_output_pin_oe,
    .capture_value_register_0, .capture_flag, .capture_irq, .halt_mode, .wake_request
);

// ---- dv/arpct_pins.sv ----
/* pin-side model: event clock, capture levels, pulled-up pwm pins.
   assumes requests move at the falling clock edge. */
`timescale 1ns/1ps
module arpct_pins (
    input wire logic clk_sys,
    input wire logic ev_run,
    input wire logic [1:0] cap_lvl,
    input wire logic [1:0] pwm_pin,
    input wire logic [1:0] pwm_oe,
    output logic event_clock_pin,
    output logic [1:0] capture_input_pin,
    output logic [1:0] pwm_seen
);
    initial event_clock_pin = 1'b0;
    // event clock stands low outside bursts
    always @(negedge clk_sys) begin
        event_clock_pin <= ev_run ? ~event_clock_pin : 1'b0;
    end
    assign capture_input_pin = cap_lvl;
    // undriven pin rests at pull-up
    assign pwm_seen = (pwm_pin & pwm_oe) | ~pwm_oe;
endmodule

// ---- dv/tb_auto_reload_pwm_capture_timer.sv ----
/* self-checking bench for arpct_timer, random and corner stimulus.
   assumes arpct_pins model and the bound port checker. */
`timescale 1ns/1ps
module tb_auto_reload_pwm_capture_timer;
    import arpct_pkg::*;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    arpct_ctl_t ctl = '0;
    arpct_pwm_ctl_t pctl = '0;
    arpct_cap_ctl_t cctl = '0;
    logic frl = 1'b0, srd = 1'b0, cwr = 1'b0, crd = 1'b0, halt = 1'b0, ev_run = 1'b0;
    logic [7:0] rld = '0, wdat = '0, cnt, cv0, cv1, pc, psh;
    logic [7:0] duty [2] = '{8'h00, 8'h00};
    logic [1:0] cap_lvl = 2'b10, pin, oe, seen, cflag, cirq, cap_pin;
    logic oflag, oirq, wake, evc;
    int err_count = 0, check_count = 0, seed = 13784, n;
    arpct_timer u_dut (
        .clk_sys(clk_sys), .rstn(rstn), .timer_control_status(ctl), .force_reload(frl),
        .status_read(srd), .overflow_flag(oflag), .overflow_irq(oirq),
        .reload_value_register(rld), .counter_write(cwr), .counter_write_data(wdat),
        .counter_access_register(cnt), .pwm_control_register(pctl),
        .duty_cycle_register_0(duty[0]), .duty_cycle_register_1(duty[1]),
        .pwm_output_pin(pin), .pwm_output_pin_oe(oe), .capture_control_status(cctl),
        .capture_status_read(crd), .capture_input_pin(cap_pin),
        .capture_value_register_0(cv0), .capture_value_register_1(cv1),
        .capture_flag(cflag), .capture_irq(cirq), .event_clock_pin(evc),
        .halt_mode(halt), .wake_request(wake));
    arpct_pins u_pins (.clk_sys(clk_sys), .ev_run(ev_run), .cap_lvl(cap_lvl), .pwm_pin(pin),
        .pwm_oe(oe), .event_clock_pin(evc), .capture_input_pin(cap_pin), .pwm_seen(seen));
    always #5 clk_sys = ~clk_sys;
    // ==========
    // tasks
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        check_count++;
        if (s !== e) begin
            err_count++;
            $display("CHECK FAILED %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge clk_sys);
    endtask
    task automatic test_done;
        $display("errors %0d checks %0d", err_count, check_count);
        if (err_count == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic rd(input logic ovf);
        if (ovf) srd = 1'b1;
        else crd = 1'b1;
        cyc(1);
        if (ovf) srd = 1'b0;
        else crd = 1'b0;
    endtask
    task automatic wait_ovf(output int k);
        k = 0;
        do begin
            cyc(1);
            k++;
        end while (oflag !== 1'b1 && k < 3000);
        if (k >= 3000) begin
            chk(8'h01, 8'h00);
            test_done();
        end
    endtask
    function automatic logic exp_pwm(input logic [7:0] c, input logic [7:0] d, input logic p);
        return ((d == 8'hFF) ? 1'b0 : (d == 8'h00) ? 1'b1 : (c <= d)) ^ p;
    endfunction
    // ==========
    // sequence
    initial begin
        cyc(16);
        rstn = 1'b1;
        cyc(1);
        chk(cnt, 8'h00);
        chk({5'h00, oflag, oe}, 8'h00);
        wdat = 8'h33;
        cwr = 1'b1;
        cyc(1);
        cwr = 1'b0;
        cyc(5);
        chk(cnt, 8'h33);
        for (int t = 0; t < 8; t++) begin
            ctl = '{1'b0, t[2:0], 1'b1, 1'b0};
            cyc(1);
            wdat = 8'h10;
            cwr = 1'b1;
            cyc(1);
            cwr = 1'b0;
            chk(cnt, 8'h10);
            cyc(1);
            n = cnt;
            cyc(4 << t);
            chk(cnt, 8'(n + 4));
        end
        rld = {4'hF, 4'($random(seed))};
        if (rld > 8'hFD) rld = 8'hFD;
        ctl = '{1'b0, 3'h0, 1'b1, 1'b1};
        frl = 1'b1;
        cyc(1);
        frl = 1'b0;
        chk(cnt, rld);
        wait_ovf(n);
        chk(cnt, rld);
        chk(8'(oirq), 8'h01);
        rd(1'b1);
        chk(8'(oflag), 8'h00);
        wait_ovf(n);
        chk(8'(n + 1), 8'(256 - rld));
        for (int p = 0; p < 2; p++) begin
            pctl = '{2'b11, {p[0], p[0]}};
            duty[0] = 8'hFE;
            duty[1] = p ? 8'h00 : 8'hFF;
            cyc(40);
            chk(8'(oe), 8'h03);
            pc = cnt;
            psh = duty[0];
            repeat (48) begin
                cyc(1);
                chk(8'(seen[0]), 8'(exp_pwm(pc, psh, p[0])));
                chk(8'(seen[1]), 8'(exp_pwm(pc, duty[1], p[0])));
                if (pc == 8'hFF && cnt != 8'hFF) psh = duty[0];
                pc = cnt;
                if (($random(seed) & 7) == 0) duty[0] = rld + 8'(1 + ($random(seed) & 255) % (254 - rld));
            end
        end
        pctl = '0;
        cyc(3);
        chk({4'h0, oe, seen}, 8'h03);
        cctl = '{2'b01, 2'b01};
        cyc(2);
        n = cnt;
        cap_lvl = 2'b01;
        cyc(1);
        chk({4'h0, cflag, cirq}, 8'h0D);
        chk(cv1, 8'(n));
        chk(cv0, 8'(n));
        cap_lvl = 2'b10;
        cyc(2);
        cap_lvl = 2'b01;
        cyc(2);
        chk(cv0, 8'(n));
        rd(1'b0);
        chk({6'h00, cflag}, 8'h00);
        cap_lvl = 2'b10;
        cyc(2);
        chk({6'h00, cflag}, 8'h00);
        n = cnt;
        cap_lvl = 2'b01;
        cyc(1);
        chk(cv0, 8'(n));
        rd(1'b0);
        cap_lvl = 2'b00;
        ctl.counter_run_enable = 1'b0;
        cyc(2);
        rd(1'b1);
        halt = 1'b1;
        cyc(2);
        chk({7'h00, wake}, 8'h00);
        cap_lvl = 2'b01;
        cyc(2);
        chk({7'h00, wake}, 8'h01);
        chk({6'h00, cirq}, 8'h01);
        chk(cv0, 8'(n));
        halt = 1'b0;
        rd(1'b0);
        ctl = '{1'b1, 3'h0, 1'b1, 1'b1};
        ev_run <= 1'b1;
        rd(1'b1);
        wait_ovf(n);
        rd(1'b1);
        halt = 1'b1;
        wait_ovf(n);
        chk(8'(n + 1), 8'(2 * (256 - rld)));
        chk({7'h00, wake}, 8'h01);
        halt = 1'b0;
        ev_run <= 1'b0;
        test_done();
    end
endmodule
